// ### hdl/spl_defs.svh
// Constants for the synthesizer programming latches: latch selects,
// field positions in each 24-bit word, reset values and cycle counts.
// Assumes inclusion by bare name from the package and the main module.
`ifndef SPL_DEFS_SVH
`define SPL_DEFS_SVH

// Serial word
`define SPL_WORD_W          24
`define SPL_WORD_RST        24'h000000

// Latch select in the two low bits
`define SPL_SEL_HI          1
`define SPL_SEL_LO          0
`define SPL_SEL_CTL         2'h0
`define SPL_SEL_REF         2'h1
`define SPL_SEL_FB          2'h2
`define SPL_SEL_TEST        2'h3

// Control word fields
`define SPL_C_PRE_HI        23
`define SPL_C_PRE_LO        22
`define SPL_C_PD_SYNC       21
`define SPL_C_PD_EN         20
`define SPL_C_CUR_B_HI      19
`define SPL_C_CUR_B_LO      17
`define SPL_C_CUR_A_HI      16
`define SPL_C_CUR_A_LO      14
`define SPL_C_PWR_HI        13
`define SPL_C_PWR_LO        12
`define SPL_C_MUTE          11
`define SPL_C_GAIN          10
`define SPL_C_TRI           9
`define SPL_C_POL           8
`define SPL_C_MON_HI        7
`define SPL_C_MON_LO        5
`define SPL_C_CRST          4
`define SPL_C_CORE_HI       3
`define SPL_C_CORE_LO       2

// Feedback divider word fields
`define SPL_N_HSRC          23
`define SPL_N_HALF          22
`define SPL_N_GAIN          21
`define SPL_N_MAIN_HI       20
`define SPL_N_MAIN_LO       8
`define SPL_N_SPARE         7
`define SPL_N_SWAL_HI       6
`define SPL_N_SWAL_LO       2

// Reference divider word fields
`define SPL_R_BSC_HI        21
`define SPL_R_BSC_LO        20
`define SPL_R_TEST          19
`define SPL_R_LDP           18
`define SPL_R_ABP_HI        17
`define SPL_R_ABP_LO        16
`define SPL_R_DIV_HI        15
`define SPL_R_DIV_LO        2

// Counts: lock in reference-divider output cycles, band search in band clock ticks
`define SPL_LOCK_CYC_FINE   3'd5
`define SPL_LOCK_CYC_COARSE 3'd3
`define SPL_BAND_CYC        3'd5
`define SPL_GAIN_RST        1'b0

`endif

// ### hdl/spl_pkg.sv
// Types for the synthesizer programming latches.
// Assumes spl_defs.svh is on the include path.
`include "spl_defs.svh"

package spl_pkg;

   typedef struct packed
   {
      logic sclk;
      logic sdata;
      logic load_strobe;
      logic chip_enable;
      logic ref_in;
      logic fb_in;
   } spl_pins_t;

   typedef struct packed
   {
      spl_pins_t meta;
      spl_pins_t stable;
   } spl_sync_st_t;

   typedef struct packed
   {
      logic [2:0] good_cnt;
      logic       locked;
   } spl_lock_st_t;

   typedef struct packed
   {
      spl_pins_t  prev;
      logic [23:0] shreg;
      logic [23:0] ctl_w;
      logic [23:0] fb_w;
      logic [23:0] ref_w;
      logic        pump_gain;
      logic        pd_latched;
      logic        pd_pend;
      logic        pd_first;
      logic        powered_down;
      logic        held;
      logic [13:0] r_cnt;
      logic        r_tick;
      logic [12:0] b_cnt;
      logic [4:0]  a_cnt;
      logic        mod_high;
      logic        n_tick;
      logic [2:0]  bs_div;
      logic        band_tick;
      logic        bs_active;
      logic [2:0]  bs_cnt;
      logic [2:0]  pump_current;
      logic        pump_tristate;
      logic        rf_enable;
      logic        ref_buf_enable;
   } spl_core_st_t;

endpackage

// ### hdl/spl_sync.sv
// Two-stage synchroniser for every pin of the serial port and the
// divider inputs. Assumes the pins are asynchronous to sys_clk.
`timescale 1ns/10ps

module spl_sync
   import spl_pkg::*;
(
   // Clock and reset
   input  wire logic      sys_clk,
   input  wire logic      sys_rst,
   // Pins in, synchronised copy out
   input  wire spl_pins_t pins_async,
   output spl_pins_t      pins_sync
);

   spl_sync_st_t s;
   spl_sync_st_t next_s;

   always_comb
   begin
      next_s        = s;
      next_s.meta   = pins_async;
      next_s.stable = s.meta;
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         s <= '0;
      else
         s <= next_s;
   end

   assign pins_sync = s.stable;

endmodule

// ### hdl/spl_lock_detect.sv
// Digital lock detect: counts reference cycles with a small phase error,
// drops lock on one cycle with a large error.
// Assumes phase_small / phase_large are judged by same-clock logic and
// are valid in the cycle that pd_cycle pulses.
`timescale 1ns/10ps
`include "spl_defs.svh"

module spl_lock_detect
   import spl_pkg::*;
(
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   // Control
   input  wire logic clear,
   input  wire logic precision,
   // Phase detector results
   input  wire logic pd_cycle,
   input  wire logic phase_small,
   input  wire logic phase_large,
   // Result
   output logic      locked
);

   spl_lock_st_t s;
   spl_lock_st_t next_s;
   logic [2:0]   target;

   always_comb
   begin
      next_s = s;
      target = precision ? `SPL_LOCK_CYC_FINE : `SPL_LOCK_CYC_COARSE;
      if (clear)
      begin
         next_s = '0;
      end
      else if (pd_cycle)
      begin
         if (s.locked)
         begin
            if (phase_large)
            begin
               next_s.locked   = 1'b0;
               next_s.good_cnt = 3'h0;
            end
         end
         else if (phase_small)
         begin
            next_s.good_cnt = s.good_cnt + 3'h1;
            if (s.good_cnt + 3'h1 >= target)
               next_s.locked = 1'b1;
         end
         else
         begin
            next_s.good_cnt = 3'h0;
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         s <= '0;
      else
         s <= next_s;
   end

   assign locked = s.locked;

endmodule

// ### hdl/spl_program_latches.sv
// Programming latches of an integer-N synthesizer: serial input register,
// control / feedback / reference words, power-down, dividers, band select.
// Assumes serial pins, chip enable and divider inputs are asynchronous;
// phase error flags come from same-clock analog measurement logic.
`timescale 1ns/10ps
`include "spl_defs.svh"

module spl_program_latches
   import spl_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   // Serial port and chip enable pins
   input  wire logic       sclk,
   input  wire logic       sdata,
   input  wire logic       load_strobe,
   input  wire logic       chip_enable,
   // Divider inputs: reference oscillator and prescaler output
   input  wire logic       ref_in,
   input  wire logic       fb_in,
   // Phase error flags per detector cycle
   input  wire logic       phase_small,
   input  wire logic       phase_large,
   // Charge pump and detector
   output logic [2:0]      pump_current,
   output logic            pump_tristate,
   output logic            detector_polarity,
   output logic [1:0]      antibacklash_width,
   // Dividers
   output logic [1:0]      prescaler_sel,
   output logic            prescaler_mod_high,
   output logic            ref_div_tick,
   output logic            fb_div_tick,
   output logic            counters_held,
   // Output stage and analog settings
   output logic            output_halving,
   output logic            halving_source,
   output logic [1:0]      output_power,
   output logic [1:0]      core_current,
   output logic [2:0]      monitor_select,
   output logic            rf_output_enable,
   output logic            ref_buffer_enable,
   // Status
   output logic            powered_down,
   output logic            lock_detect,
   output logic            band_select_active,
   output logic            band_clock_tick
);

   spl_pins_t    pins_raw;
   spl_pins_t    pins;
   spl_core_st_t s;
   spl_core_st_t next_s;
   logic         locked;
   logic [12:0]  main_val;
   logic [4:0]   swal_val;
   logic [13:0]  ref_val;
   logic [2:0]   band_last;
   logic         sclk_rise;
   logic         le_rise;
   logic         ref_rise;
   logic         fb_rise;

   assign pins_raw = '{sclk:        sclk,
                       sdata:       sdata,
                       load_strobe: load_strobe,
                       chip_enable: chip_enable,
                       ref_in:      ref_in,
                       fb_in:       fb_in};

   spl_sync u_sync
   (
      .sys_clk    (sys_clk),
      .sys_rst    (sys_rst),
      .pins_async (pins_raw),
      .pins_sync  (pins)
   );

   // Lock detector runs on reference-divider ticks as detector cycles
   spl_lock_detect u_lock
   (
      .sys_clk     (sys_clk),
      .sys_rst     (sys_rst),
      .clear       (s.powered_down),
      .precision   (s.ref_w[`SPL_R_LDP]),
      .pd_cycle    (s.r_tick),
      .phase_small (phase_small),
      .phase_large (phase_large),
      .locked      (locked)
   );

   always_comb
   begin
      next_s    = s;
      sclk_rise = pins.sclk & ~s.prev.sclk;
      le_rise   = pins.load_strobe & ~s.prev.load_strobe;
      ref_rise  = pins.ref_in & ~s.prev.ref_in;
      fb_rise   = pins.fb_in & ~s.prev.fb_in;
      next_s.prev = pins;

      // Shifting never depends on power-down state
      if (sclk_rise)
         next_s.shreg = {s.shreg[22:0], pins.sdata};

      if (le_rise)
      begin
         case (s.shreg[`SPL_SEL_HI:`SPL_SEL_LO])
            `SPL_SEL_CTL:
            begin
               next_s.ctl_w     = s.shreg;
               next_s.pump_gain = s.shreg[`SPL_C_GAIN];
               if (!s.shreg[`SPL_C_PD_EN])
               begin
                  next_s.pd_latched = 1'b0;
                  next_s.pd_pend    = 1'b0;
               end
               else if (!s.shreg[`SPL_C_PD_SYNC])
               begin
                  next_s.pd_latched = 1'b1;
                  next_s.pd_pend    = 1'b0;
               end
               else
               begin
                  next_s.pd_pend  = 1'b1;
                  next_s.pd_first = 1'b0;
               end
            end
            `SPL_SEL_FB:
            begin
               next_s.fb_w      = s.shreg;
               next_s.pump_gain = s.shreg[`SPL_N_GAIN];
               next_s.bs_active = 1'b1;
               next_s.bs_cnt    = 3'h0;
            end
            `SPL_SEL_REF:
               next_s.ref_w = s.shreg;
            // Factory test latch is not implemented, its word is dropped
            `SPL_SEL_TEST:
               next_s.ctl_w = s.ctl_w;
            default:
               next_s.ctl_w = s.ctl_w;
         endcase
      end

      // Synchronous power-down waits for the second reference tick
      if (s.pd_pend && s.r_tick && !le_rise)
      begin
         if (s.pd_first)
         begin
            next_s.pd_latched = 1'b1;
            next_s.pd_pend    = 1'b0;
         end
         else
            next_s.pd_first = 1'b1;
      end

      next_s.powered_down = ~pins.chip_enable | next_s.pd_latched;
      next_s.held = s.powered_down | s.ctl_w[`SPL_C_CRST];

      // Reference divider; zero behaves as one
      ref_val = s.ref_w[`SPL_R_DIV_HI:`SPL_R_DIV_LO];
      next_s.r_tick = 1'b0;
      if (s.held)
         next_s.r_cnt = 14'h0000;
      else if (ref_rise)
      begin
         if ({1'b0, s.r_cnt} + 15'h0001 >= {1'b0, ref_val})
         begin
            next_s.r_cnt  = 14'h0000;
            next_s.r_tick = 1'b1;
         end
         else
            next_s.r_cnt = s.r_cnt + 14'h0001;
      end

      // Pulse swallow: modulus P+1 for the first swallow cycles, P after
      main_val = s.fb_w[`SPL_N_MAIN_HI:`SPL_N_MAIN_LO];
      swal_val = s.fb_w[`SPL_N_SWAL_HI:`SPL_N_SWAL_LO];
      next_s.n_tick = 1'b0;
      if (s.held)
      begin
         next_s.b_cnt = 13'h0000;
         next_s.a_cnt = 5'h00;
      end
      else if (fb_rise)
      begin
         if ({1'b0, s.b_cnt} + 14'h0001 >= {1'b0, main_val})
         begin
            next_s.b_cnt  = 13'h0000;
            next_s.a_cnt  = 5'h00;
            next_s.n_tick = 1'b1;
         end
         else
         begin
            next_s.b_cnt = s.b_cnt + 13'h0001;
            if (s.a_cnt < swal_val)
               next_s.a_cnt = s.a_cnt + 5'h01;
         end
      end
      next_s.mod_high = (next_s.a_cnt < swal_val);

      // Band select clock divider and five-cycle band search
      band_last = (3'h1 << s.ref_w[`SPL_R_BSC_HI:`SPL_R_BSC_LO]) - 3'h1;
      next_s.band_tick = 1'b0;
      if (s.powered_down)
         next_s.bs_div = 3'h0;
      else if (s.r_tick)
      begin
         if (s.bs_div >= band_last)
         begin
            next_s.bs_div    = 3'h0;
            next_s.band_tick = 1'b1;
         end
         else
            next_s.bs_div = s.bs_div + 3'h1;
      end
      if (s.bs_active && s.band_tick && !(le_rise && next_s.bs_cnt == 3'h0))
      begin
         next_s.bs_cnt = s.bs_cnt + 3'h1;
         if (s.bs_cnt + 3'h1 >= `SPL_BAND_CYC)
            next_s.bs_active = 1'b0;
      end

      // Pump current and output enables
      next_s.pump_current = s.pump_gain ? s.ctl_w[`SPL_C_CUR_B_HI:`SPL_C_CUR_B_LO]
                                        : s.ctl_w[`SPL_C_CUR_A_HI:`SPL_C_CUR_A_LO];
      next_s.pump_tristate  = s.powered_down | s.ctl_w[`SPL_C_TRI];
      next_s.rf_enable      = ~s.powered_down & ~(s.ctl_w[`SPL_C_MUTE] & ~locked);
      next_s.ref_buf_enable = ~s.powered_down;
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         s           <= '0;
         s.ctl_w     <= `SPL_WORD_RST;
         s.fb_w      <= `SPL_WORD_RST;
         s.ref_w     <= `SPL_WORD_RST;
         s.pump_gain <= `SPL_GAIN_RST;
         s.bs_active <= 1'b1;
      end
      else
         s <= next_s;
   end

   // Outputs come straight from the latched words and registered state
   assign pump_current       = s.pump_current;
   assign pump_tristate      = s.pump_tristate;
   assign detector_polarity  = s.ctl_w[`SPL_C_POL];
   assign antibacklash_width = s.ref_w[`SPL_R_ABP_HI:`SPL_R_ABP_LO];
   assign prescaler_sel      = s.ctl_w[`SPL_C_PRE_HI:`SPL_C_PRE_LO];
   assign prescaler_mod_high = s.mod_high;
   assign ref_div_tick       = s.r_tick;
   assign fb_div_tick        = s.n_tick;
   assign counters_held      = s.held;
   assign output_halving     = s.fb_w[`SPL_N_HALF];
   assign halving_source     = s.fb_w[`SPL_N_HSRC];
   assign output_power       = s.ctl_w[`SPL_C_PWR_HI:`SPL_C_PWR_LO];
   assign core_current       = s.ctl_w[`SPL_C_CORE_HI:`SPL_C_CORE_LO];
   assign monitor_select     = s.ctl_w[`SPL_C_MON_HI:`SPL_C_MON_LO];
   assign rf_output_enable   = s.rf_enable;
   assign ref_buffer_enable  = s.ref_buf_enable;
   assign powered_down       = s.powered_down;
   assign lock_detect        = locked;
   assign band_select_active = s.bs_active;
   assign band_clock_tick    = s.band_tick;

endmodule

// ### verif/spl_program_latches_properties.sv
// Checker for the programming latches: ties status outputs to their causes.
// Assumes binding to spl_program_latches; one clock domain.
`timescale 1ns/10ps

module spl_program_latches_properties
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Pins and flags
   input wire logic chip_enable,
   input wire logic phase_large,
   // Watched outputs
   input wire logic pump_tristate,
   input wire logic ref_div_tick,
   input wire logic fb_div_tick,
   input wire logic counters_held,
   input wire logic rf_output_enable,
   input wire logic ref_buffer_enable,
   input wire logic powered_down,
   input wire logic lock_detect,
   input wire logic band_select_active,
   input wire logic band_clock_tick
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   sequence s_big_err;
      lock_detect && ref_div_tick && phase_large;
   endsequence
   sequence s_quiet_ref;
      (!ref_div_tick) [*3];
   endsequence

   // Outputs settle one edge after entry, so look from the second cycle
   property p_pd_outputs;
      powered_down [*2] |-> pump_tristate && !rf_output_enable
         && !ref_buffer_enable && !lock_detect && counters_held;
   endproperty
   property p_ce_off;
      (!chip_enable) [*6] |-> powered_down;
   endproperty
   property p_lock_drop;
      s_big_err |-> ##[1:2] !lock_detect;
   endproperty
   property p_ref_pulse;
      ref_div_tick |=> !ref_div_tick;
   endproperty
   property p_fb_pulse;
      fb_div_tick |=> !fb_div_tick;
   endproperty
   property p_held_quiet;
      counters_held [*3] |-> !ref_div_tick && !fb_div_tick;
   endproperty
   property p_band_src;
      s_quiet_ref |=> !band_clock_tick;
   endproperty
   property p_band_end;
      $fell(band_select_active) |->
         band_clock_tick || $past(band_clock_tick) || $past(band_clock_tick, 2);
   endproperty

   a_pd_outputs: assert property (p_pd_outputs)
      else $error("outputs live in power-down");
   a_ce_off: assert property (p_ce_off)
      else $error("chip enable low but not powered down");
   a_lock_drop: assert property (p_lock_drop)
      else $error("lock kept after large phase error");
   a_ref_pulse: assert property (p_ref_pulse)
      else $error("reference tick longer than one cycle");
   a_fb_pulse: assert property (p_fb_pulse)
      else $error("feedback tick longer than one cycle");
   a_held_quiet: assert property (p_held_quiet)
      else $error("divider tick while counters held");
   a_band_src: assert property (p_band_src)
      else $error("band clock tick without reference tick");
   a_band_end: assert property (p_band_end)
      else $error("band select ended without band clock tick");
endmodule

bind spl_program_latches spl_program_latches_properties i_props
(
   .sys_clk, .sys_rst, .chip_enable, .phase_large, .pump_tristate, .ref_div_tick,
   .fb_div_tick, .counters_held, .rf_output_enable, .ref_buffer_enable,
   .powered_down, .lock_detect, .band_select_active, .band_clock_tick
);

// ### verif/spl_host_model.sv
// Host microcontroller model: writes 24-bit words over the 3-wire port.
// Assumes callers enter send just after a sys_clk edge.
`timescale 1ns/10ps

module spl_host_model
(
   // Clock
   input  wire logic sys_clk,
   // Serial port pins
   output logic      sclk,
   output logic      sdata,
   output logic      load_strobe
);
   // Level hold in clock cycles; 1 is the fastest the port accepts
   int hold_cyc = 6;

   initial
   begin
      sclk = 1'b0;
      sdata = 1'b0;
      load_strobe = 1'b0;
   end

   task automatic hold();
      repeat (hold_cyc) @(posedge sys_clk);
      #1;
   endtask

   task automatic send(input logic [23:0] word);
      for (int i = 23; i >= 0; i--)
      begin
         sdata = word[i];
         hold();
         sclk = 1'b1;
         hold();
         sclk = 1'b0;
      end
      // Data line carries no meaning outside a frame
      sdata = ~word[0];
      hold();
      load_strobe = 1'b1;
      hold();
      load_strobe = 1'b0;
      hold();
   endtask
endmodule

// ### verif/testbench.sv
// Self-checking bench for the synthesizer programming latches.
// Assumes the host model drives the serial pins; the bench drives the rest.
`timescale 1ns/10ps

module testbench;
   logic       sys_clk, sys_rst, sclk, sdata, load_strobe, chip_enable;
   logic       ref_in, fb_in, phase_small, phase_large, ref_run;
   logic [2:0] pump_current, monitor_select;
   logic [1:0] antibacklash_width, prescaler_sel, output_power, core_current;
   logic       pump_tristate, detector_polarity, prescaler_mod_high, ref_div_tick;
   logic       fb_div_tick, counters_held, output_halving, halving_source;
   logic       rf_output_enable, ref_buffer_enable, powered_down, lock_detect;
   logic       band_select_active, band_clock_tick;
   int         n_errors = 0, tests_run = 0, cycles = 0, ref_cnt = 0, fb_cnt = 0;
   int         g, hi;
   logic [2:0] tk;

   assign tk = {band_clock_tick, fb_div_tick, ref_div_tick};

   spl_host_model i_host (.sys_clk, .sclk, .sdata, .load_strobe);

   spl_program_latches i_dut
   (
      .sys_clk, .sys_rst, .sclk, .sdata, .load_strobe, .chip_enable, .ref_in, .fb_in,
      .phase_small, .phase_large, .pump_current, .pump_tristate, .detector_polarity,
      .antibacklash_width, .prescaler_sel, .prescaler_mod_high, .ref_div_tick,
      .fb_div_tick, .counters_held, .output_halving, .halving_source, .output_power,
      .core_current, .monitor_select, .rf_output_enable, .ref_buffer_enable,
      .powered_down, .lock_detect, .band_select_active, .band_clock_tick
   );

   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // Reference edges every 10 cycles, prescaler edges every 8
   always @(posedge sys_clk)
   begin
      ref_cnt <= ref_cnt + 1;
      fb_cnt <= fb_cnt + 1;
      cycles <= cycles + 1;
      if (ref_run && ref_cnt % 5 == 4)
         ref_in <= #1 ~ref_in;
      if (fb_cnt % 4 == 3)
         fb_in <= #1 ~fb_in;
      if (cycles == 20000)
      begin
         n_errors++;
         end_sim();
      end
   end

   task automatic end_sim();
      if (n_errors == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic ticks(input int n);
      for (int i = 0; i < n; i++)
      begin
         @(posedge sys_clk);
         while (ref_div_tick !== 1'b1)
            @(posedge sys_clk);
      end
      cyc(3);
   endtask

   // Period of one tick (0 reference, 1 feedback, 2 band), modulus-high cycles in it
   task automatic gap(input int sel, output int p, output int h);
      p = 0;
      h = 0;
      @(posedge sys_clk);
      while (tk[sel] !== 1'b1)
         @(posedge sys_clk);
      do
      begin
         @(posedge sys_clk);
         p++;
         h += (prescaler_mod_high === 1'b1);
      end while (tk[sel] !== 1'b1);
      #1;
   endtask

   task automatic wr(input logic [23:0] w);
      i_host.send(w);
      cyc(8);
   endtask

   // Spare bits always go out as zero; divide ratio 2, band clock halved
   task automatic wref(input logic lock_precision_bit, input logic [1:0] abp);
      wr({2'b00, 2'b01, 1'b0, lock_precision_bit, abp, 14'd2, 2'b01});
   endtask

   task automatic wctl(input logic mute, gain, tris, crst, input logic [1:0] pd);
      wr({2'b01, pd, 3'b101, 3'b011, 2'b10, mute, gain, tris, 1'b1, 3'b110, crst,
          2'b01, 2'b00});
   endtask

   task automatic wfb(input logic gain);
      wr({1'b1, 1'b0, gain, 13'd5, 1'b0, 5'd3, 2'b10});
   endtask

   initial
   begin
      sys_rst = 1'b1;
      chip_enable = 1'b1;
      ref_in = 1'b0;
      fb_in = 1'b0;
      phase_small = 1'b0;
      phase_large = 1'b0;
      ref_run = 1'b1;
      repeat (5) @(posedge sys_clk);
      #1;
      sys_rst = 1'b0;
      cyc(4);
      wref(1'b0, 2'b10);
      wctl(1'b1, 1'b0, 1'b0, 1'b0, 2'b00);
      wfb(1'b1);
      chk("abp", antibacklash_width, 2);
      chk("presc", prescaler_sel, 1);
      chk("power", output_power, 2);
      chk("core", core_current, 1);
      chk("mon", monitor_select, 6);
      chk("pol", detector_polarity, 1);
      chk("tri", pump_tristate, 0);
      chk("cur fb", pump_current, 5);
      chk("half", output_halving, 0);
      chk("hsrc", halving_source, 1);
      chk("band", band_select_active, 1);
      chk("muted", rf_output_enable, 0);
      gap(0, g, hi);
      chk("ref gap", g, 20);
      gap(1, g, hi);
      chk("fb gap", g, 40);
      chk("mod hi", hi, 24);
      // Band clock is the reference tick halved
      gap(2, g, hi);
      chk("band gap", g, 40);
      i_host.hold_cyc = 3;
      wctl(1'b1, 1'b0, 1'b0, 1'b0, 2'b00);
      i_host.hold_cyc = 6;
      chk("cur ctl", pump_current, 3);
      chk("band done", band_select_active, 0);
      phase_small = 1'b1;
      ticks(2);
      chk("lock 2", lock_detect, 0);
      ticks(1);
      chk("lock 3", lock_detect, 1);
      chk("unmuted", rf_output_enable, 1);
      phase_small = 1'b0;
      ticks(2);
      chk("lock held", lock_detect, 1);
      phase_large = 1'b1;
      ticks(1);
      phase_large = 1'b0;
      chk("lock lost", lock_detect, 0);
      wref(1'b1, 2'b10);
      phase_small = 1'b1;
      ticks(4);
      chk("lock 4", lock_detect, 0);
      ticks(1);
      chk("lock 5", lock_detect, 1);
      phase_small = 1'b0;
      wr(24'hFFFFFF);
      chk("test word", antibacklash_width, 2);
      wctl(1'b0, 1'b0, 1'b1, 1'b1, 2'b00);
      chk("tri on", pump_tristate, 1);
      chk("held", counters_held, 1);
      cyc(60);
      wctl(1'b0, 1'b0, 1'b0, 1'b0, 2'b01);
      chk("pd", powered_down, 1);
      chk("pd tri", pump_tristate, 1);
      chk("pd rf", rf_output_enable, 0);
      chk("pd buf", ref_buffer_enable, 0);
      chk("pd lock", lock_detect, 0);
      chk("pd held", counters_held, 1);
      wref(1'b1, 2'b01);
      chk("pd load", antibacklash_width, 1);
      wctl(1'b0, 1'b0, 1'b0, 1'b0, 2'b00);
      chk("pd off", powered_down, 0);
      chk("buf on", ref_buffer_enable, 1);
      // Reference held still so no tick slips in before the word lands
      ref_run = 1'b0;
      wctl(1'b0, 1'b0, 1'b0, 1'b0, 2'b11);
      ref_run = 1'b1;
      ticks(1);
      chk("spd 1", powered_down, 0);
      ticks(1);
      chk("spd 2", powered_down, 1);
      wctl(1'b0, 1'b0, 1'b0, 1'b0, 2'b00);
      chip_enable = 1'b0;
      cyc(6);
      chk("ce pd", powered_down, 1);
      chip_enable = 1'b1;
      cyc(6);
      chk("ce up", powered_down, 0);
      end_sim();
   end
endmodule
